// >>> design/oag_top.sv
`timescale 1ns/1ps
// Operand address generator: segment choice and effective offset

module oag_top
	import oag_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         req_valid,
	input  wire oag_mode_type req_mode,
	input  wire oag_ref_type  req_ref,
	input  wire logic         base_sel_bp,
	input  wire logic         index_sel_di,
	input  wire oag_ind_type  ind_sel,
	input  wire logic         disp_is_word,
	input  wire logic [15:0]  disp,
	input  wire logic         override_valid,
	input  wire oag_seg_type  override_seg,
	input  wire logic [15:0]  data_segment_reg,
	input  wire logic [15:0]  code_segment_reg,
	input  wire logic [15:0]  stack_segment_reg,
	input  wire logic [15:0]  extra_segment_reg,
	input  wire logic [15:0]  general_base_reg,
	input  wire logic [15:0]  base_pointer_reg,
	input  wire logic [15:0]  src_index_reg,
	input  wire logic [15:0]  dest_index_reg,
	input  wire logic [15:0]  acc_extension_reg,
	input  wire logic [15:0]  accumulator_reg,
	input  wire logic [7:0]   check_byte,
	output logic              addr_valid,
	output logic              no_mem,
	output oag_seg_type       seg_sel,
	output logic [15:0]       seg_value,
	output logic [15:0]       offset,
	output logic [19:0]       phys_addr,
	output logic [31:0]       double_word,
	output logic              double_neg,
	output logic              bcd_valid
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Displacement as used in the sum
	function automatic logic [15:0] disp_ext(input logic [15:0] d,
		input logic is_word);
		logic [15:0] r;
		r = is_word ? d : {{8{d[7]}}, d[7:0]};
		return r;
	endfunction : disp_ext

	// Three-term 16-bit sum with carry dropped
	function automatic logic [15:0] sum16(input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c);
		logic [17:0] s;
		s = {2'b00, a} + {2'b00, b} + {2'b00, c};
		return s[15:0];
	endfunction : sum16

	// Segment value for a selector
	function automatic logic [15:0] seg_word(input oag_seg_type s,
		input logic [15:0] d, input logic [15:0] c,
		input logic [15:0] st, input logic [15:0] e);
		logic [15:0] r;
		case (s)
			OAG_SEG_DATA:  r = d;
			OAG_SEG_CODE:  r = c;
			OAG_SEG_STACK: r = st;
			default:       r = e;
		endcase
		return r;
	endfunction : seg_word

	// ****************************************************************
	// Address components
	// ****************************************************************
	logic [15:0]  base_val;
	logic [15:0]  index_val;
	logic [15:0]  disp_val;
	logic [15:0]  ind_val;
	logic         uses_bp;
	logic [15:0]  next_offset;
	logic         next_no_mem;
	oag_seg_type  implied_seg;
	oag_seg_type  next_seg;

	// Base and index register choice
	assign base_val  = base_sel_bp ? base_pointer_reg
		: general_base_reg;
	assign index_val = index_sel_di ? dest_index_reg
		: src_index_reg;
	assign disp_val  = disp_ext(disp, disp_is_word);

	// Register indirect source
	always_comb begin
		case (ind_sel)
			OAG_IND_SRC_IDX:  ind_val = src_index_reg;
			OAG_IND_DST_IDX:  ind_val = dest_index_reg;
			OAG_IND_GEN_BASE: ind_val = general_base_reg;
			default:          ind_val = base_pointer_reg;
		endcase
	end

	// Effective offset per mode
	always_comb begin
		next_no_mem = 1'b0;
		case (req_mode)
			OAG_MODE_DIRECT:
				next_offset = disp_val;
			OAG_MODE_REG_IND:
				next_offset = ind_val;
			OAG_MODE_BASED:
				next_offset = sum16(disp_val, base_val,
					OAG_ZERO_WORD);
			OAG_MODE_INDEXED:
				next_offset = sum16(disp_val, index_val,
					OAG_ZERO_WORD);
			OAG_MODE_BASED_IDX:
				next_offset = sum16(base_val, index_val,
					OAG_ZERO_WORD);
			OAG_MODE_BIDX_DISP:
				next_offset = sum16(base_val, index_val,
					disp_val);
			default: begin
				next_offset = OAG_ZERO_WORD;
				next_no_mem = 1'b1;
			end
		endcase
	end

	// Does the offset involve the base pointer
	always_comb begin
		case (req_mode)
			OAG_MODE_REG_IND:
				uses_bp = (ind_sel == OAG_IND_BASE_PTR);
			OAG_MODE_BASED, OAG_MODE_BASED_IDX, OAG_MODE_BIDX_DISP:
				uses_bp = base_sel_bp;
			default:
				uses_bp = 1'b0;
		endcase
	end

	// ****************************************************************
	// Segment selection
	// ****************************************************************

	// Implied segment from reference kind
	always_comb begin
		case (req_ref)
			OAG_REF_FETCH:  implied_seg = OAG_SEG_CODE;
			OAG_REF_STACK:  implied_seg = OAG_SEG_STACK;
			OAG_REF_STRDST: implied_seg = OAG_SEG_EXTRA;
			default:
				implied_seg = uses_bp ? OAG_SEG_STACK
					: OAG_SEG_DATA;
		endcase
	end

	// Override applies to data and string source operands only
	always_comb begin
		if (override_valid && req_ref != OAG_REF_FETCH &&
			req_ref != OAG_REF_STACK &&
			req_ref != OAG_REF_STRDST) begin
			next_seg = override_seg;
		end else begin
			next_seg = implied_seg;
		end
	end

	// ****************************************************************
	// Registered result toward the bus unit
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_valid <= 1'b0;
			no_mem     <= 1'b0;
			seg_sel    <= OAG_SEG_DATA;
			seg_value  <= OAG_ZERO_WORD;
			offset     <= OAG_ZERO_WORD;
		end else begin
			addr_valid <= req_valid && !next_no_mem;
			no_mem     <= req_valid && next_no_mem;
			if (req_valid) begin
				seg_sel   <= next_seg;
				seg_value <= seg_word(next_seg, data_segment_reg,
					code_segment_reg, stack_segment_reg,
					extra_segment_reg);
				offset    <= next_offset;
			end
		end
	end

	// Physical address: segment times sixteen plus offset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phys_addr <= OAG_ZERO_PHYS;
		end else if (req_valid) begin
			phys_addr <= {next_seg_word(), 4'h0}
				+ {4'h0, next_offset};
		end
	end

	// Segment word of the pending selection
	function automatic logic [15:0] next_seg_word();
		return seg_word(next_seg, data_segment_reg, code_segment_reg,
			stack_segment_reg, extra_segment_reg);
	endfunction : next_seg_word

	// ****************************************************************
	// Data-type conventions
	// ****************************************************************
	logic [15:0] byte_sext_unused;

	oag_data_check u_data_check (
		.byte_val          (check_byte),
		.acc_extension_reg (acc_extension_reg),
		.accumulator_reg   (accumulator_reg),
		.byte_sext         (byte_sext_unused),
		.double_word       (double_word),
		.double_neg        (double_neg),
		.bcd_valid         (bcd_valid)
	);

endmodule : oag_top

// >>> design/oag_pkg.sv
// Package of constants and types for the operand address generator
package oag_pkg;

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int             OAG_WORD_W     = 16;
	localparam int             OAG_PHYS_W     = 20;
	localparam int             OAG_SEG_SHIFT  = 4;
	localparam logic [15:0]    OAG_ZERO_WORD  = 16'h0000;
	localparam logic [19:0]    OAG_ZERO_PHYS  = 20'h00000;
	localparam logic [3:0]     OAG_BCD_MAX    = 4'h9;
	localparam int             OAG_LATENCY    = 1;

	// Operand / addressing mode, as delivered by the decoder
	typedef enum logic [3:0] {
		OAG_MODE_REG       = 4'h0,
		OAG_MODE_IMM       = 4'h1,
		OAG_MODE_DIRECT    = 4'h2,
		OAG_MODE_REG_IND   = 4'h3,
		OAG_MODE_BASED     = 4'h4,
		OAG_MODE_INDEXED   = 4'h5,
		OAG_MODE_BASED_IDX = 4'h6,
		OAG_MODE_BIDX_DISP = 4'h7
	} oag_mode_type;

	// Kind of memory reference
	typedef enum logic [2:0] {
		OAG_REF_DATA   = 3'h0,
		OAG_REF_FETCH  = 3'h1,
		OAG_REF_STACK  = 3'h2,
		OAG_REF_STRDST = 3'h3,
		OAG_REF_STRSRC = 3'h4
	} oag_ref_type;

	// Segment register selector
	typedef enum logic [1:0] {
		OAG_SEG_EXTRA = 2'h0,
		OAG_SEG_CODE  = 2'h1,
		OAG_SEG_STACK = 2'h2,
		OAG_SEG_DATA  = 2'h3
	} oag_seg_type;

	// Register indirect selector
	typedef enum logic [1:0] {
		OAG_IND_SRC_IDX = 2'h0,
		OAG_IND_DST_IDX = 2'h1,
		OAG_IND_GEN_BASE = 2'h2,
		OAG_IND_BASE_PTR = 2'h3
	} oag_ind_type;

endpackage : oag_pkg

// >>> design/oag_data_check.sv
`timescale 1ns/1ps
// Data-type helper: sign extension, double word and packed decimal checks
module oag_data_check
	import oag_pkg::*;
(
	input  wire logic [7:0]  byte_val,
	input  wire logic [15:0] acc_extension_reg,
	input  wire logic [15:0] accumulator_reg,
	output logic      [15:0] byte_sext,
	output logic      [31:0] double_word,
	output logic             double_neg,
	output logic             bcd_valid
);

	// ****************************************************************
	// Two's complement extension of a byte
	// ****************************************************************
	assign byte_sext = {{8{byte_val[7]}}, byte_val};

	// ****************************************************************
	// Double word from the extension and accumulator pair
	// ****************************************************************
	assign double_word = {acc_extension_reg, accumulator_reg};
	assign double_neg  = acc_extension_reg[15];

	// ****************************************************************
	// Packed decimal: each nibble at most nine
	// ****************************************************************
	assign bcd_valid = (byte_val[7:4] <= OAG_BCD_MAX) &&
		(byte_val[3:0] <= OAG_BCD_MAX);

endmodule : oag_data_check

// >>> sim/oag_chk_asserts.sv
// Checker of the operand address generator ports
`timescale 1ns/1ps
module oag_chk
	import oag_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst_b,
	input wire logic         req_valid,
	input wire oag_mode_type req_mode,
	input wire oag_ref_type  req_ref,
	input wire logic         override_valid,
	input wire oag_seg_type  override_seg,
	input wire logic [15:0]  acc_extension_reg,
	input wire logic [15:0]  accumulator_reg,
	input wire logic [7:0]   check_byte,
	input wire logic         addr_valid,
	input wire logic         no_mem,
	input wire oag_seg_type  seg_sel,
	input wire logic [15:0]  seg_value,
	input wire logic [15:0]  offset,
	input wire logic [19:0]  phys_addr,
	input wire logic [31:0]  double_word,
	input wire logic         bcd_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic mem_req;

	// Memory-mode request flag
	assign mem_req = req_valid && req_mode > OAG_MODE_IMM;

	property p_mem;
		mem_req |=> addr_valid && !no_mem;
	endproperty
	a_mem: assert property (p_mem) else $error("no address");
	property p_fetch;
		mem_req && req_ref == OAG_REF_FETCH |=> seg_sel == OAG_SEG_CODE;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch seg");
	property p_stack;
		mem_req && req_ref == OAG_REF_STACK |=> seg_sel == OAG_SEG_STACK;
	endproperty
	a_stack: assert property (p_stack) else $error("stack seg");
	property p_strdst;
		mem_req && req_ref == OAG_REF_STRDST |=> seg_sel == OAG_SEG_EXTRA;
	endproperty
	a_strdst: assert property (p_strdst) else $error("dst seg");
	property p_ovr;
		mem_req && override_valid && req_ref == OAG_REF_DATA
			|=> seg_sel == $past(override_seg);
	endproperty
	a_ovr: assert property (p_ovr) else $error("override seg");
	property p_phys;
		addr_valid |-> phys_addr == {seg_value, 4'h0} + {4'h0, offset};
	endproperty
	a_phys: assert property (p_phys) else $error("phys addr");
	property p_dword;
		double_word == {acc_extension_reg, accumulator_reg};
	endproperty
	a_dword: assert property (p_dword) else $error("double word");
	property p_bcd;
		bcd_valid == (check_byte[7:4] <= 4'h9 && check_byte[3:0] <= 4'h9);
	endproperty
	a_bcd: assert property (p_bcd) else $error("packed decimal");
endmodule : oag_chk

bind oag_top oag_chk oag_chk_i (
	.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_mode(req_mode),
	.req_ref(req_ref), .override_valid(override_valid),
	.override_seg(override_seg), .acc_extension_reg(acc_extension_reg),
	.accumulator_reg(accumulator_reg), .check_byte(check_byte),
	.addr_valid(addr_valid), .no_mem(no_mem), .seg_sel(seg_sel),
	.seg_value(seg_value), .offset(offset), .phys_addr(phys_addr),
	.double_word(double_word), .bcd_valid(bcd_valid)
);

// >>> sim/oag_regs_model.sv
// Register file model standing in for the decoder side
`timescale 1ns/1ps
module oag_regs_model
(
	input  wire logic        bank,
	output logic [9:0][15:0] regs
);
	// Two banks; bank one pushes every sum past the 16-bit boundary
	always_comb begin
		if (bank) begin
			regs = {16'h8001, 16'h7FFF, 16'hFFFE, 16'hFFF0, 16'hFFF8,
				16'hFFF0, 16'hF000, 16'hE000, 16'hFFFF, 16'hFFFF};
		end else begin
			regs = {16'h0001, 16'h8000, 16'h0200, 16'h0100, 16'h0020,
				16'h0010, 16'h4000, 16'h3000, 16'h2000, 16'h1000};
		end
	end
endmodule : oag_regs_model

// >>> sim/test_operand_address_generator.sv
// Self-checking testbench for the operand address generator
`timescale 1ns/1ps
module test_operand_address_generator
	import oag_pkg::*;
;
	logic clk, rst_b, req_valid, base_sel_bp, index_sel_di, disp_is_word;
	logic override_valid, bank, addr_valid, no_mem, double_neg, bcd_valid;
	oag_mode_type req_mode;
	oag_ref_type req_ref;
	oag_ind_type ind_sel;
	oag_seg_type override_seg, seg_sel;
	logic [15:0] disp, seg_value, offset;
	logic [7:0] check_byte;
	logic [19:0] phys_addr;
	logic [31:0] double_word;
	logic [9:0][15:0] regs;
	int n_errors, comparisons;

	oag_regs_model oag_regs_model_i (.bank(bank), .regs(regs));
	oag_top oag_top_i (
		.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_mode(req_mode),
		.req_ref(req_ref), .base_sel_bp(base_sel_bp),
		.index_sel_di(index_sel_di), .ind_sel(ind_sel),
		.disp_is_word(disp_is_word), .disp(disp),
		.override_valid(override_valid), .override_seg(override_seg),
		.data_segment_reg(regs[0]), .code_segment_reg(regs[1]),
		.stack_segment_reg(regs[2]), .extra_segment_reg(regs[3]),
		.general_base_reg(regs[4]), .base_pointer_reg(regs[5]),
		.src_index_reg(regs[6]), .dest_index_reg(regs[7]),
		.acc_extension_reg(regs[8]), .accumulator_reg(regs[9]),
		.check_byte(check_byte), .addr_valid(addr_valid), .no_mem(no_mem),
		.seg_sel(seg_sel), .seg_value(seg_value), .offset(offset),
		.phys_addr(phys_addr), .double_word(double_word),
		.double_neg(double_neg), .bcd_valid(bcd_valid)
	);

	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One request, then the registered answer one cycle later
	task automatic go(input oag_mode_type m, input oag_ref_type r,
		input logic w, input logic o, input logic s);
		logic [15:0] d, b, i, eo, sv;
		logic [19:0] ph;
		oag_seg_type es;
		logic mem;
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_mode = m;
		req_ref = r;
		disp_is_word = w;
		override_valid = o;
		base_sel_bp = s;
		index_sel_di = s;
		ind_sel = s ? OAG_IND_BASE_PTR : OAG_IND_SRC_IDX;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		d = w ? disp : {{8{disp[7]}}, disp[7:0]};
		b = s ? regs[5] : regs[4];
		i = s ? regs[7] : regs[6];
		mem = m > OAG_MODE_IMM;
		case (m)
			OAG_MODE_DIRECT: eo = d;
			OAG_MODE_REG_IND: eo = s ? b : i;
			OAG_MODE_BASED: eo = d + b;
			OAG_MODE_INDEXED: eo = d + i;
			OAG_MODE_BASED_IDX: eo = b + i;
			OAG_MODE_BIDX_DISP: eo = b + i + d;
			default: eo = 16'h0000;
		endcase
		case (r)
			OAG_REF_FETCH: es = OAG_SEG_CODE;
			OAG_REF_STACK: es = OAG_SEG_STACK;
			OAG_REF_STRDST: es = OAG_SEG_EXTRA;
			default: es = o ? override_seg : (s && m != OAG_MODE_DIRECT &&
				m != OAG_MODE_INDEXED) ? OAG_SEG_STACK : OAG_SEG_DATA;
		endcase
		case (es)
			OAG_SEG_DATA: sv = regs[0];
			OAG_SEG_CODE: sv = regs[1];
			OAG_SEG_STACK: sv = regs[2];
			default: sv = regs[3];
		endcase
		ph = {sv, 4'h0} + {4'h0, eo};
		chk(addr_valid, mem);
		chk(no_mem, !mem);
		chk(offset, eo);
		if (mem) begin
			chk(seg_sel, es);
			chk(seg_value, sv);
			chk(phys_addr, ph);
		end
	endtask : go

	// Every mode with byte and word displacement, both register choices
	task automatic t_modes(input logic k);
		bank = k;
		disp = k ? 16'h0081 : 16'h12F0;
		for (int n = 0; n < 32; n++) begin
			go(oag_mode_type'(n % 8), OAG_REF_DATA, n / 16, 1'b0, n / 8 % 2);
		end
		$display("modes done, bank %0d", k);
	endtask : t_modes

	// Every reference kind against each override segment and no override; base choice alternates, so no override runs only without base pointer
	task automatic t_segs();
		bank = 1'b0;
		for (int r = 0; r < 5; r++) begin
			for (int q = 0; q < 5; q++) begin
				override_seg = oag_seg_type'(q % 4);
				go(OAG_MODE_BASED, oag_ref_type'(r), 1'b1, q < 4, q % 2);
			end
		end
		$display("segments done");
	endtask : t_segs

	// Double word and packed decimal views
	task automatic t_data();
		logic [7:0] v [4] = '{8'h99, 8'h9A, 8'hA9, 8'h00};
		for (int k = 0; k < 4; k++) begin
			bank = k % 2;
			check_byte = v[k];
			#1;
			chk(double_word, {regs[8], regs[9]});
			chk(double_neg, regs[8][15]);
			chk(bcd_valid, k == 0 || k == 3);
		end
		$display("data done");
	endtask : t_data

	task automatic tally_and_finish();
		$display("comparisons %0d, errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial begin
		{rst_b, req_valid, base_sel_bp, index_sel_di, disp_is_word} = '0;
		{override_valid, bank, disp, check_byte} = '0;
		req_mode = OAG_MODE_REG;
		req_ref = OAG_REF_DATA;
		ind_sel = OAG_IND_SRC_IDX;
		override_seg = OAG_SEG_EXTRA;
		repeat (4) @(posedge clk);
		#1;
		rst_b = 1'b1;
		t_modes(1'b0);
		t_modes(1'b1);
		t_segs();
		t_data();
		tally_and_finish();
	end
endmodule : test_operand_address_generator
